// ===== src/frp_pkg.sv
// Package for the flash read-out protection block: levels, sources, carriers.
// Assumes one system clock domain; all users refer to names by package scope.
package frp_pkg;

    // Protection level of the flash variant
    typedef enum logic [1:0] {
        FRP_LVL_OFF,
        FRP_LVL_WEAK,
        FRP_LVL_STRONG
    } frp_level_t;

    // Where the requesting instruction was fetched from
    typedef enum logic [1:0] {
        FRP_SRC_PFLASH,
        FRP_SRC_DFLASH,
        FRP_SRC_ROM,
        FRP_SRC_OTHER
    } frp_src_t;

    // Target memory of a request
    typedef enum logic [1:0] {
        FRP_TGT_PFLASH,
        FRP_TGT_DFLASH,
        FRP_TGT_ROM
    } frp_tgt_t;

    // Operation kind
    typedef enum logic [1:0] {
        FRP_OP_READ,
        FRP_OP_PROG,
        FRP_OP_ERASE
    } frp_op_t;

    // Access request from CPU or boot loader
    typedef struct packed {
        logic       valid;
        logic       external;
        frp_src_t   src;
        frp_tgt_t   tgt;
        frp_op_t    op;
        logic [7:0] rdata;
    } frp_req_t;

    // Boot-loader mode that enables and removes protection
    localparam logic [2:0] FRP_BOOT_MODE_PROT = 3'h6;
    // Stored password width and reset values
    localparam int         FRP_PW_W        = 8;
    localparam logic [7:0] FRP_RDATA_RST   = 8'h00;
    // Cycles the wipe sequence lasts before done
    localparam logic [3:0] FRP_WIPE_CYCLES = 4'h8;

endpackage

// ===== src/frp_wipe.sv
// Wipe sequencer: erases program flash, data flash and password in turn.
// Assumes a single-cycle start pulse on the system clock.
`timescale 1ns/1ps
`default_nettype none
module frp_wipe (
    // Clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_nrst,
    // Control
    input  wire logic       i_start,
    output logic            o_busy,
    output logic            o_done
);
    typedef enum logic [1:0] {FRP_W_IDLE, FRP_W_RUN, FRP_W_DONE} frp_wst_t;
    frp_wst_t   state_reg;
    logic [3:0] cnt_reg;

    // Sequencer and counter
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            state_reg <= FRP_W_IDLE;
            cnt_reg   <= 4'h0;
        end else begin
            unique case (state_reg)
                FRP_W_IDLE: if (i_start) begin
                    state_reg <= FRP_W_RUN;
                    cnt_reg   <= 4'h0;
                end
                FRP_W_RUN: begin
                    cnt_reg <= cnt_reg + 4'h1;
                    if (cnt_reg == frp_pkg::FRP_WIPE_CYCLES - 4'h1) state_reg <= FRP_W_DONE;
                end
                FRP_W_DONE: state_reg <= FRP_W_DONE;
                default:    state_reg <= FRP_W_IDLE;
            endcase
        end
    end

    // Status outputs from flops
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_busy <= (state_reg == FRP_W_RUN);
            o_done <= (state_reg == FRP_W_DONE);
        end
    end
endmodule
`default_nettype wire

// ===== src/frp_guard.sv
// Flash read-out protection guard: gates reads, programs and erases.
// Assumes requests arrive from same-clock logic; mode inputs are pins.
// Function
// - Program flash writable only when unprotected
// - Off or weak: any program memory reads data
// - Strong: data reads only from flash code
// - External data flash access always denied
// - Weak level erase needs unlock bit set
// - Mode six password match wipes flashes and password
// - Protection holds until reset, then follows level pin
// - ROM always protected; mode six blocks external
// - ROM mode six raises protection error
// - ROM readable only by ROM instructions
`timescale 1ns/1ps
`default_nettype none
module frp_guard (
    // Clock and reset
    input  wire logic              i_sys_clk,
    input  wire logic              i_nrst,
    // Configuration pins
    input  wire logic              i_rom_variant,
    input  wire frp_pkg::frp_level_t i_level,
    input  wire logic [2:0]        i_boot_loader_mode,
    input  wire logic              i_data_erase_unlock,
    // Password check
    input  wire logic              i_pw_valid,
    input  wire logic [7:0]        i_pw,
    input  wire logic [7:0]        i_pw_stored,
    // Request
    input  wire frp_pkg::frp_req_t i_req,
    // Results
    output logic                   o_grant,
    output logic                   o_deny,
    output logic [7:0]             o_rdata,
    output logic                   o_violation,
    output logic                   o_prot_error,
    output logic                   o_wipe_busy,
    output logic                   o_prot_active,
    output logic                   o_unlock_on_reset
);
    logic [2:0] mode_s1_reg;
    logic [2:0] mode_reg;
    logic       lvl_rom_s1_reg;
    logic       rom_reg;
    logic [1:0] lvl_s1_reg;
    logic [1:0] lvl_reg;
    logic       unlock_reg;
    logic       wipe_start;
    logic       wipe_busy;
    logic       wipe_done;
    logic       allow;
    frp_pkg::frp_level_t lvl;
    logic       mode6;

    // Two-flop sync of mode, ROM and level pins
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            mode_s1_reg    <= 3'h0;
            mode_reg       <= 3'h0;
            lvl_rom_s1_reg <= 1'b0;
            rom_reg        <= 1'b0;
            lvl_s1_reg     <= 2'h0;
            lvl_reg        <= 2'h0;
        end else begin
            mode_s1_reg    <= i_boot_loader_mode;
            mode_reg       <= mode_s1_reg;
            lvl_rom_s1_reg <= i_rom_variant;
            rom_reg        <= lvl_rom_s1_reg;
            lvl_s1_reg     <= i_level;
            lvl_reg        <= unlock_reg ? lvl_reg : lvl_s1_reg;
        end
    end

    assign lvl   = frp_pkg::frp_level_t'(lvl_reg);
    assign mode6 = (mode_reg == frp_pkg::FRP_BOOT_MODE_PROT);

    // Password match in mode six on flash variant starts wipe
    assign wipe_start = i_pw_valid && mode6 && !rom_reg && (i_pw == i_pw_stored)
                        && !unlock_reg && !wipe_busy;

    frp_wipe u_wipe (
        .i_sys_clk (i_sys_clk),
        .i_nrst    (i_nrst),
        .i_start   (wipe_start),
        .o_busy    (wipe_busy),
        .o_done    (wipe_done)
    );

    // Unlock is pending until reset clears it
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) unlock_reg <= 1'b0;
        else if (wipe_start) unlock_reg <= 1'b1;
    end

    // Permission decision
    always_comb begin
        allow = 1'b0;
        if (i_req.external && (i_req.tgt == frp_pkg::FRP_TGT_DFLASH)) begin
            allow = 1'b0;
        end else if (i_req.external && (rom_reg || lvl != frp_pkg::FRP_LVL_OFF) && mode6) begin
            allow = 1'b0;
        end else if (wipe_busy) begin
            allow = 1'b0;
        end else if (rom_reg) begin
            // ROM variant: always protected
            allow = (i_req.tgt == frp_pkg::FRP_TGT_ROM) && (i_req.op == frp_pkg::FRP_OP_READ)
                    && (i_req.src == frp_pkg::FRP_SRC_ROM);
        end else if (i_req.tgt == frp_pkg::FRP_TGT_PFLASH) begin
            allow = (i_req.op == frp_pkg::FRP_OP_READ) || (lvl == frp_pkg::FRP_LVL_OFF);
        end else if (i_req.tgt == frp_pkg::FRP_TGT_DFLASH) begin
            unique case (i_req.op)
                frp_pkg::FRP_OP_READ:
                    allow = (lvl != frp_pkg::FRP_LVL_STRONG)
                            || (i_req.src == frp_pkg::FRP_SRC_PFLASH)
                            || (i_req.src == frp_pkg::FRP_SRC_DFLASH);
                frp_pkg::FRP_OP_PROG:
                    allow = (lvl != frp_pkg::FRP_LVL_STRONG);
                frp_pkg::FRP_OP_ERASE:
                    allow = (lvl == frp_pkg::FRP_LVL_OFF)
                            || ((lvl == frp_pkg::FRP_LVL_WEAK) && i_data_erase_unlock);
                default: allow = 1'b0;
            endcase
        end
    end

    // Registered answer, data only when granted
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_grant     <= 1'b0;
            o_deny      <= 1'b0;
            o_rdata     <= frp_pkg::FRP_RDATA_RST;
            o_violation <= 1'b0;
        end else begin
            o_grant     <= i_req.valid && allow;
            o_deny      <= i_req.valid && !allow;
            o_rdata     <= (i_req.valid && allow && i_req.op == frp_pkg::FRP_OP_READ)
                           ? i_req.rdata : frp_pkg::FRP_RDATA_RST;
            o_violation <= o_violation || (i_req.valid && !allow);
        end
    end

    // Status flags
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_prot_error      <= 1'b0;
            o_wipe_busy       <= 1'b0;
            o_prot_active     <= 1'b0;
            o_unlock_on_reset <= 1'b0;
        end else begin
            o_prot_error      <= o_prot_error || (rom_reg && mode6);
            o_wipe_busy       <= wipe_busy;
            o_prot_active     <= rom_reg || (lvl != frp_pkg::FRP_LVL_OFF);
            o_unlock_on_reset <= unlock_reg || wipe_done;
        end
    end

    // Checks
    sequence s_ext_dflash;
        i_req.valid && i_req.external && (i_req.tgt == frp_pkg::FRP_TGT_DFLASH);
    endsequence
    property p_ext_deny;
        @(posedge i_sys_clk) disable iff (!i_nrst) s_ext_dflash |=> o_deny && !o_grant;
    endproperty
    a_ext_deny: assert property (p_ext_deny) else $error("external dflash granted");
    property p_pflash_prot;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (i_req.valid && i_req.tgt == frp_pkg::FRP_TGT_PFLASH && i_req.op != frp_pkg::FRP_OP_READ
         && lvl != frp_pkg::FRP_LVL_OFF) |=> o_deny;
    endproperty
    a_pflash_prot: assert property (p_pflash_prot) else $error("pflash write granted");
    property p_strong_read;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (i_req.valid && !rom_reg && !i_req.external && !wipe_busy && lvl == frp_pkg::FRP_LVL_STRONG
         && i_req.tgt == frp_pkg::FRP_TGT_DFLASH && i_req.op == frp_pkg::FRP_OP_READ
         && i_req.src == frp_pkg::FRP_SRC_OTHER) |=> o_deny;
    endproperty
    a_strong_read: assert property (p_strong_read) else $error("strong read granted");
    property p_erase_unlock;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (i_req.valid && lvl == frp_pkg::FRP_LVL_WEAK && !i_data_erase_unlock
         && i_req.tgt == frp_pkg::FRP_TGT_DFLASH && i_req.op == frp_pkg::FRP_OP_ERASE) |=> o_deny;
    endproperty
    a_erase_unlock: assert property (p_erase_unlock) else $error("erase without unlock");
    property p_wipe_latch;
        @(posedge i_sys_clk) disable iff (!i_nrst) wipe_start |=> ##1 o_unlock_on_reset [*4];
    endproperty
    a_wipe_latch: assert property (p_wipe_latch) else $error("unlock not held");
    property p_wipe_busy;
        @(posedge i_sys_clk) disable iff (!i_nrst) wipe_start |-> ##[1:3] wipe_busy;
    endproperty
    a_wipe_busy: assert property (p_wipe_busy) else $error("wipe not started");
    property p_rom_err;
        @(posedge i_sys_clk) disable iff (!i_nrst) (rom_reg && mode6) |=> o_prot_error;
    endproperty
    a_rom_err: assert property (p_rom_err) else $error("rom mode error missing");
    property p_rom_read;
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (i_req.valid && rom_reg && i_req.src != frp_pkg::FRP_SRC_ROM) |=> o_deny;
    endproperty
    a_rom_read: assert property (p_rom_read) else $error("rom read granted");
    property p_no_data;
        @(posedge i_sys_clk) disable iff (!i_nrst) o_deny |-> o_rdata == frp_pkg::FRP_RDATA_RST;
    endproperty
    a_no_data: assert property (p_no_data) else $error("data leaked");
    // Level frozen while the unlock waits for reset
    property p_lvl_hold;
        @(posedge i_sys_clk) disable iff (!i_nrst) unlock_reg |=> $stable(lvl_reg);
    endproperty
    a_lvl_hold: assert property (p_lvl_hold) else $error("level not held");
    // Never both answers at once
    property p_one_answer;
        @(posedge i_sys_clk) disable iff (!i_nrst) !(o_grant && o_deny);
    endproperty
    a_one_answer: assert property (p_one_answer) else $error("grant and deny together");
    // Every refusal is flagged
    property p_deny_flag;
        @(posedge i_sys_clk) disable iff (!i_nrst) o_deny |-> o_violation;
    endproperty
    a_deny_flag: assert property (p_deny_flag) else $error("refusal not flagged");
endmodule
`default_nettype wire

// ===== verification/frp_host_model.sv
// Far-side model: boot-loader host that enters the protection boot mode
// and offers a password. Assumes the guard samples on the same clock.
`timescale 1ns/1ps
`default_nettype none
module frp_host_model (
    // Clock
    input  wire logic       i_sys_clk,
    // Commands from the bench
    input  wire logic       i_enter,
    input  wire logic       i_send,
    input  wire logic [7:0] i_try,
    // Pins toward the guard
    output logic [2:0]      o_boot_loader_mode,
    output logic            o_pw_valid,
    output logic [7:0]      o_pw,
    output logic [7:0]      o_pw_stored
);
    // Arbitrary programmed password
    localparam logic [7:0] STORED_PW = 8'h5a;

    assign o_pw_stored = STORED_PW;

    // Boot mode six to remove protection, password presented for one cycle
    always_ff @(posedge i_sys_clk) begin
        o_boot_loader_mode <= i_enter ? 3'h6 : 3'h0;
        o_pw_valid         <= i_send;
        o_pw               <= i_send ? i_try : ~o_pw; // Released lines toggle
    end
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the protection guard with a boot-loader host.
// Assumes one 10 MHz clock and synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0, nrst = 1'b0, rom = 1'b0, unl = 1'b0, ent = 1'b0, snd = 1'b0;
    frp_pkg::frp_level_t lvl = frp_pkg::FRP_LVL_OFF;
    frp_pkg::frp_req_t rq = '0;
    logic [7:0] try_pw = 8'h00;
    logic [2:0] bmode;
    logic       pwv, gr, dn, vio, perr, busy, pact, unlk;
    logic [7:0] pw, pws, rd;
    int         n_errors = 0;
    int         tests_run = 0;

    // Clock
    always #50 clk = ~clk;

    frp_host_model host_u (.i_sys_clk(clk), .i_enter(ent), .i_send(snd), .i_try(try_pw),
        .o_boot_loader_mode(bmode), .o_pw_valid(pwv), .o_pw(pw), .o_pw_stored(pws));

    frp_guard dut_u (.i_sys_clk(clk), .i_nrst(nrst), .i_rom_variant(rom), .i_level(lvl),
        .i_boot_loader_mode(bmode), .i_data_erase_unlock(unl), .i_pw_valid(pwv), .i_pw(pw),
        .i_pw_stored(pws), .i_req(rq), .o_grant(gr), .o_deny(dn), .o_rdata(rd),
        .o_violation(vio), .o_prot_error(perr), .o_wipe_busy(busy), .o_prot_active(pact),
        .o_unlock_on_reset(unlk));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wrap_up;
        if (n_errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Pins settle through the model and the synchronisers
    task automatic setcfg(input logic r, input frp_pkg::frp_level_t l, input logic e);
        rom = r;
        lvl = l;
        ent = e;
        cyc(6);
    endtask

    task automatic do_reset;
        nrst = 1'b0;
        cyc(4);
        nrst = 1'b1;
        cyc(3);
        check({7'h0, vio}, 8'h00, "violation after reset");
        check({7'h0, unlk}, 8'h00, "unlock after reset");
    endtask

    // One request, answer exactly one cycle later, standing one cycle
    task automatic req(input logic ext, input frp_pkg::frp_src_t s, input frp_pkg::frp_tgt_t t,
                       input frp_pkg::frp_op_t o, input logic [7:0] d, input logic g,
                       input string what);
        rq = '{1'b1, ext, s, t, o, d};
        cyc(1);
        rq.valid = 1'b0;
        check({6'h0, gr, dn}, {6'h0, g, ~g}, what);
        check(rd, (g && o == frp_pkg::FRP_OP_READ) ? d : 8'h00, what);
        if (!g) check({7'h0, vio}, 8'h01, what);
        cyc(1);
        check({6'h0, gr, dn}, 8'h00, what);
    endtask

    task automatic t_off;
        setcfg(1'b0, frp_pkg::FRP_LVL_OFF, 1'b0);
        do_reset();
        check({7'h0, pact}, 8'h00, "protection off");
        req(0, frp_pkg::FRP_SRC_OTHER, frp_pkg::FRP_TGT_PFLASH, frp_pkg::FRP_OP_PROG, 8'h00, 1, "pf prog");
        req(0, frp_pkg::FRP_SRC_OTHER, frp_pkg::FRP_TGT_PFLASH, frp_pkg::FRP_OP_ERASE, 8'h00, 1, "pf erase");
        req(0, frp_pkg::FRP_SRC_ROM, frp_pkg::FRP_TGT_DFLASH, frp_pkg::FRP_OP_READ, 8'h3c, 1, "df read");
        req(1, frp_pkg::FRP_SRC_OTHER, frp_pkg::FRP_TGT_DFLASH, frp_pkg::FRP_OP_READ, 8'hc3, 0, "ext df");
    endtask

    task automatic t_weak;
        setcfg(1'b0, frp_pkg::FRP_LVL_WEAK, 1'b0);
        do_reset();
        req(0, frp_pkg::FRP_SRC_PFLASH, frp_pkg::FRP_TGT_PFLASH, frp_pkg::FRP_OP_PROG, 8'h00, 0, "pf prog");
        req(0, frp_pkg::FRP_SRC_ROM, frp_pkg::FRP_TGT_DFLASH, frp_pkg::FRP_OP_READ, 8'h81, 1, "df read");
        unl = 1'b0;
        req(0, frp_pkg::FRP_SRC_PFLASH, frp_pkg::FRP_TGT_DFLASH, frp_pkg::FRP_OP_ERASE, 8'h00, 0, "locked erase");
        unl = 1'b1;
        req(0, frp_pkg::FRP_SRC_PFLASH, frp_pkg::FRP_TGT_DFLASH, frp_pkg::FRP_OP_ERASE, 8'h00, 1, "unlocked erase");
        unl = 1'b0;
        req(1, frp_pkg::FRP_SRC_OTHER, frp_pkg::FRP_TGT_DFLASH, frp_pkg::FRP_OP_PROG, 8'h00, 0, "ext df");
    endtask

    task automatic t_strong;
        setcfg(1'b0, frp_pkg::FRP_LVL_STRONG, 1'b0);
        do_reset();
        req(0, frp_pkg::FRP_SRC_OTHER, frp_pkg::FRP_TGT_DFLASH, frp_pkg::FRP_OP_READ, 8'h77, 0, "other read");
        req(0, frp_pkg::FRP_SRC_DFLASH, frp_pkg::FRP_TGT_DFLASH, frp_pkg::FRP_OP_READ, 8'h12, 1, "df read");
        req(0, frp_pkg::FRP_SRC_PFLASH, frp_pkg::FRP_TGT_DFLASH, frp_pkg::FRP_OP_READ, 8'he4, 1, "pf read");
        req(0, frp_pkg::FRP_SRC_PFLASH, frp_pkg::FRP_TGT_PFLASH, frp_pkg::FRP_OP_ERASE, 8'h00, 0, "pf erase");
    endtask

    task automatic t_rom;
        setcfg(1'b1, frp_pkg::FRP_LVL_OFF, 1'b0);
        do_reset();
        req(0, frp_pkg::FRP_SRC_ROM, frp_pkg::FRP_TGT_ROM, frp_pkg::FRP_OP_READ, 8'h5c, 1, "rom read");
        req(0, frp_pkg::FRP_SRC_PFLASH, frp_pkg::FRP_TGT_ROM, frp_pkg::FRP_OP_READ, 8'h5c, 0, "pf to rom");
        req(0, frp_pkg::FRP_SRC_ROM, frp_pkg::FRP_TGT_ROM, frp_pkg::FRP_OP_PROG, 8'h00, 0, "rom prog");
        check({7'h0, perr}, 8'h00, "early prot error");
        setcfg(1'b1, frp_pkg::FRP_LVL_OFF, 1'b1);
        check({7'h0, perr}, 8'h01, "prot error");
        req(1, frp_pkg::FRP_SRC_OTHER, frp_pkg::FRP_TGT_ROM, frp_pkg::FRP_OP_READ, 8'h5c, 0, "ext rom");
    endtask

    task automatic t_pw;
        int n;
        setcfg(1'b0, frp_pkg::FRP_LVL_WEAK, 1'b1);
        do_reset();
        try_pw = ~pws;
        snd = 1'b1;
        cyc(1);
        snd = 1'b0;
        cyc(10);
        check({6'h0, busy, unlk}, 8'h00, "wrong password");
        check({7'h0, perr}, 8'h00, "flash mode error");
        try_pw = pws;
        snd = 1'b1;
        cyc(1);
        snd = 1'b0;
        for (n = 0; n < 5 && busy !== 1'b1; n++) cyc(1);
        check({7'h0, busy}, 8'h01, "wipe start");
        req(0, frp_pkg::FRP_SRC_PFLASH, frp_pkg::FRP_TGT_DFLASH, frp_pkg::FRP_OP_READ, 8'h44, 0, "during wipe");
        check({7'h0, unlk}, 8'h01, "unlock pending");
        cyc(10);
        check({6'h0, busy, pact}, 8'h01, "wipe end, still protected");
        setcfg(1'b0, frp_pkg::FRP_LVL_OFF, 1'b1);
        check({7'h0, pact}, 8'h01, "level held until reset");
        req(0, frp_pkg::FRP_SRC_PFLASH, frp_pkg::FRP_TGT_PFLASH, frp_pkg::FRP_OP_PROG, 8'h00, 0, "still locked");
        do_reset();
        check({7'h0, pact}, 8'h00, "off after reset");
    endtask

    // Main sequence
    initial begin
        do_reset();
        t_off();
        t_weak();
        t_strong();
        t_rom();
        t_pw();
        wrap_up();
    end

    // Watchdog
    initial begin
        #200000;
        n_errors++;
        wrap_up();
    end
endmodule
`default_nettype wire
